//--- rtl/hsd_cfg.svh
// Offsets, field positions, reset values and timing counts of the driver
`ifndef HSD_CFG_SVH
`define HSD_CFG_SVH

// ****************************************
// Register offsets
// ****************************************
`define HSD_OFS_DATA 3'h0
`define HSD_OFS_CONFIG 3'h1
`define HSD_OFS_STATUS 3'h5
`define HSD_OFS_IRQ_EN 3'h6
`define HSD_OFS_IRQ_FLAG 3'h7

// ****************************************
// Field positions
// ****************************************
`define HSD_BIT_DATA 0
`define HSD_BIT_ENABLE 0
`define HSD_BIT_OL_DET 2
`define HSD_BIT_OC_MASK 4
`define HSD_BIT_OL_STAT 0
`define HSD_BIT_OC_IE 7
`define HSD_BIT_OC_FLAG 0

// ****************************************
// Reset values and timing
// ****************************************
`define HSD_RST_BYTE 8'h00
`define HSD_CLK_HZ 25000000
`define HSD_OC_MASK_NS 10000
`define HSD_OC_MASK_CYC ((`HSD_OC_MASK_NS * 25) / 1000)

`endif

//--- rtl/hsd_pkg.sv
// Types shared by the driver control files
package hsd_pkg;
    typedef logic [7:0] hsd_byte_t;
    typedef logic [2:0] hsd_addr_t;
    typedef enum logic [1:0] {
        HSD_OFF = 2'b00,
        HSD_MASKED = 2'b01,
        HSD_ON = 2'b11
    } hsd_drv_state_t;
endpackage

//--- rtl/hsd_sync2.sv
// Two-flop synchroniser for one comparator level
`timescale 1ns/100ps
module hsd_sync2 (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic d_async,
    output logic q_sync
);
    logic s1_reg;
    logic s2_reg;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
        end else begin
            s1_reg <= d_async;
            s2_reg <= s1_reg;
        end
    end

    assign q_sync = s2_reg;
endmodule

//--- rtl/hsd_mask_timer.sv
// Masking window counter started at each driver switch-on
`timescale 1ns/100ps
module hsd_mask_timer #(
    parameter int MASK_CYCLES = 250
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic start,
    input wire logic abort,
    output logic active
);
    localparam int CW = $clog2(MASK_CYCLES + 1);
    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] cnt_next;

    if (MASK_CYCLES < 1) begin : g_bad_cycles
        $error("MASK_CYCLES must be at least 1");
    end

    always_comb begin
        cnt_next = cnt_reg;
        if (abort) begin
            cnt_next = '0;
        end else if (start) begin
            cnt_next = CW'(MASK_CYCLES);
        end else if (cnt_reg != '0) begin
            cnt_next = cnt_reg - 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign active = (cnt_reg != '0);
endmodule

//--- rtl/hsd_top.sv
// High-side driver control, open-load and over-current protection
//
// What this block does
// - Status bit 0 follows the open-load comparator; read only.
// - With enable bit 7 set, interrupt request follows over-current flag.
// - Writing 1 clears the over-current flag; writing 0 does nothing.
// - Over-current comparator sets flag bit 0; it stays until cleared.
// - A set over-current flag forces the driver command off.
// - Once cleared, the driver follows the routed control source again.
// - On/off command comes from data bit or routed timer/PWM channel.
// - Open-load detection active only: enabled, driver enabled, source off.
// - Active detection reports open load when pin stays above threshold.
// - Mask enable ignores over-current for a window after each switch-on.
// - Mask enable bit writable only while the driver enable is 0.
// - Interrupt request is made only in run mode.
// - Stop mode entry or exit leaves the over-current flag untouched.
// - Driver enable biases the stage; disabled driver never turns on.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/100ps
`include "hsd_cfg.svh"
module hsd_top #(
    parameter int MASK_CYCLES = `HSD_OC_MASK_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire hsd_pkg::hsd_addr_t bus_addr,
    input wire hsd_pkg::hsd_byte_t bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output hsd_pkg::hsd_byte_t bus_rdata,
    input wire logic route_sel_timer,
    input wire logic timer_pwm_in,
    input wire logic run_mode,
    input wire logic oc_comp_in,
    input wire logic ol_comp_in,
    output logic drv_bias,
    output logic drv_on,
    output logic ol_detect_on,
    output logic irq_req
);
    import hsd_pkg::*;

    // ****************************************
    // Parameter check
    // ****************************************
    // An empty window is the mask enable cleared, not a zero count
    if (MASK_CYCLES < 1) begin : g_bad_mask
        $error("MASK_CYCLES must be at least 1");
    end

    // ****************************************
    // Input synchronisation
    // ****************************************
    logic oc_sync;
    logic ol_sync;
    logic tmr_sync;

    hsd_sync2 u_sync_oc (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .d_async(oc_comp_in),
        .q_sync(oc_sync)
    );
    hsd_sync2 u_sync_ol (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .d_async(ol_comp_in),
        .q_sync(ol_sync)
    );
    hsd_sync2 u_sync_tmr (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .d_async(timer_pwm_in),
        .q_sync(tmr_sync)
    );

    // ****************************************
    // Registers
    // ****************************************
    logic data_reg, data_next;
    logic en_reg, en_next;
    logic oldet_reg, oldet_next;
    logic ocm_reg, ocm_next;
    logic ocie_reg, ocie_next;
    logic ocf_reg, ocf_next;
    logic olst_reg, olst_next;
    hsd_byte_t rdata_reg, rdata_next;
    logic src_on;
    logic mask_active;
    logic oc_event;
    logic wr_cfg;
    logic wr_flag;
    logic w1c;

    assign wr_cfg = bus_wr && (bus_addr == `HSD_OFS_CONFIG);
    assign wr_flag = bus_wr && (bus_addr == `HSD_OFS_IRQ_FLAG);
    assign w1c = wr_flag && bus_wdata[`HSD_BIT_OC_FLAG];

    // Source selection from the routing unit
    assign src_on = route_sel_timer ? tmr_sync : data_reg;

    always_comb begin
        data_next = data_reg;
        en_next = en_reg;
        oldet_next = oldet_reg;
        ocm_next = ocm_reg;
        ocie_next = ocie_reg;
        if (bus_wr && (bus_addr == `HSD_OFS_DATA)) begin
            data_next = bus_wdata[`HSD_BIT_DATA];
        end
        if (wr_cfg) begin
            en_next = bus_wdata[`HSD_BIT_ENABLE];
            oldet_next = bus_wdata[`HSD_BIT_OL_DET];
            if (!en_reg) begin
                ocm_next = bus_wdata[`HSD_BIT_OC_MASK];
            end
        end
        if (bus_wr && (bus_addr == `HSD_OFS_IRQ_EN)) begin
            ocie_next = bus_wdata[`HSD_BIT_OC_IE];
        end
    end

    // ****************************************
    // Driver state and masking window
    // ****************************************
    hsd_drv_state_t st_reg, st_next;
    logic cmd_on;
    logic switch_on;

    // Command before the flag gate; switch_on (state off, flag clear) starts the mask window when ocm_reg is set
    assign cmd_on = en_reg && src_on;
    assign switch_on = cmd_on && (st_reg == HSD_OFF) && !ocf_reg;

    hsd_mask_timer #(
        .MASK_CYCLES(MASK_CYCLES)
    ) u_mask (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .start(switch_on && ocm_reg),
        .abort(!cmd_on),
        .active(mask_active)
    );

    // Comparator ignored during the window; only an enabled stage can trip
    assign oc_event = oc_sync && en_reg && !mask_active && !switch_on;

    always_comb begin
        st_next = st_reg;
        case (st_reg)
            HSD_OFF: begin
                if (switch_on) begin
                    st_next = ocm_reg ? HSD_MASKED : HSD_ON;
                end
            end
            HSD_MASKED: begin
                if (!cmd_on || ocf_next) begin
                    st_next = HSD_OFF;
                end else if (!mask_active) begin
                    st_next = HSD_ON;
                end
            end
            HSD_ON: begin
                if (!cmd_on || ocf_next) begin
                    st_next = HSD_OFF;
                end
            end
            default: begin
                st_next = HSD_OFF;
            end
        endcase
    end

    // ****************************************
    // Over-current flag and open-load status
    // ****************************************
    // Stop mode has no input here, so it cannot touch the flag
    always_comb begin
        ocf_next = ocf_reg;
        if (w1c) begin
            ocf_next = 1'b0;
        end
        if (oc_event) begin
            ocf_next = 1'b1;
        end
    end

    logic ol_active;
    // Detection only while enabled, biased and the source commands off
    assign ol_active = oldet_reg && en_reg && !src_on;

    always_comb begin
        olst_next = ol_active && ol_sync;
    end

    always_comb begin
        rdata_next = 8'h00;
        if (bus_rd) begin
            if (bus_addr == `HSD_OFS_DATA) begin
                rdata_next[`HSD_BIT_DATA] = data_reg;
            end else if (bus_addr == `HSD_OFS_CONFIG) begin
                rdata_next[`HSD_BIT_ENABLE] = en_reg;
                rdata_next[`HSD_BIT_OL_DET] = oldet_reg;
                rdata_next[`HSD_BIT_OC_MASK] = ocm_reg;
            end else if (bus_addr == `HSD_OFS_STATUS) begin
                rdata_next[`HSD_BIT_OL_STAT] = olst_reg;
            end else if (bus_addr == `HSD_OFS_IRQ_EN) begin
                rdata_next[`HSD_BIT_OC_IE] = ocie_reg;
            end else if (bus_addr == `HSD_OFS_IRQ_FLAG) begin
                rdata_next[`HSD_BIT_OC_FLAG] = ocf_reg;
            end else begin
                rdata_next = 8'h00;
            end
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    logic drv_on_next;
    logic irq_next;

    // Gated with next flag and enable so shutdown and disable land at once
    assign drv_on_next = cmd_on && en_next && !ocf_next;
    assign irq_next = ocie_next && ocf_next && run_mode;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            data_reg <= 1'b0;
            en_reg <= 1'b0;
            oldet_reg <= 1'b0;
            ocm_reg <= 1'b0;
            ocie_reg <= 1'b0;
            ocf_reg <= 1'b0;
            olst_reg <= 1'b0;
            st_reg <= HSD_OFF;
            rdata_reg <= `HSD_RST_BYTE;
            drv_bias <= 1'b0;
            drv_on <= 1'b0;
            ol_detect_on <= 1'b0;
            irq_req <= 1'b0;
        end else begin
            data_reg <= data_next;
            en_reg <= en_next;
            oldet_reg <= oldet_next;
            ocm_reg <= ocm_next;
            ocie_reg <= ocie_next;
            ocf_reg <= ocf_next;
            olst_reg <= olst_next;
            st_reg <= st_next;
            rdata_reg <= rdata_next;
            drv_bias <= en_next;
            drv_on <= drv_on_next;
            ol_detect_on <= ol_active;
            irq_req <= irq_next;
        end
    end

    assign bus_rdata = rdata_reg;

    // ****************************************
    // Checks
    // ****************************************
    // Cycles spent masked, so the window length can be bounded cheaply
    localparam int MW = $clog2(MASK_CYCLES + 2);
    logic [MW-1:0] mcnt_reg;
    logic [MW-1:0] mcnt_next;

    always_comb begin
        mcnt_next = '0;
        if (st_reg == HSD_MASKED) begin
            mcnt_next = mcnt_reg + MW'(1);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mcnt_reg <= '0;
        end else begin
            mcnt_reg <= mcnt_next;
        end
    end

    AST_IRQ_FOLLOWS: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        irq_req == (ocie_reg && ocf_reg && $past(run_mode)))
        else $error("irq request does not follow enabled flag");
    AST_IRQ_RUN_ONLY: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        irq_req |-> $past(run_mode) && ocf_reg && ocie_reg)
        else $error("irq request outside run mode or without flag");
    AST_IRQ_NO_IE: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !ocie_reg |-> !irq_req)
        else $error("irq request while interrupt disabled");
    AST_FLAG_STICKY: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        ocf_reg && !w1c |=> ocf_reg)
        else $error("over-current flag lost without clear");
    AST_W0_KEEPS: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        wr_flag && !bus_wdata[`HSD_BIT_OC_FLAG] && ocf_reg |=> ocf_reg)
        else $error("write zero cleared the flag");
    AST_W1C: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        w1c && !oc_event |=> !ocf_reg)
        else $error("write one did not clear the flag");
    AST_SET_WINS: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        oc_event |=> ocf_reg)
        else $error("over-current event lost");
    AST_FORCED_OFF: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        ocf_reg |-> !drv_on)
        else $error("driver on while flag set");
    AST_DISABLED_OFF: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        !drv_bias |-> !drv_on)
        else $error("disabled driver turned on");
    AST_DRV_ROUTE: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        $past(en_reg) && en_reg && !ocf_reg |-> drv_on ==
        ($past(route_sel_timer) ? $past(tmr_sync) : $past(data_reg)))
        else $error("driver command does not follow routed source");
    AST_MASK_LOCK: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        wr_cfg && en_reg |=> $stable(ocm_reg))
        else $error("mask enable changed while driver enabled");
    AST_MASK_HOLD: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        mask_active && !ocf_reg |=> !ocf_reg)
        else $error("over-current flag set inside mask window");
    AST_MASK_LEN: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        mcnt_reg <= MW'(MASK_CYCLES + 1))
        else $error("mask window longer than its count");
    AST_OL_GATE: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        olst_reg |-> $past(oldet_reg) && $past(en_reg) && !$past(src_on))
        else $error("open load reported while detection inactive");
    AST_DETECT_GATE: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        ol_detect_on == ($past(oldet_reg) && $past(en_reg)
        && !$past(src_on)))
        else $error("test current does not follow detection gate");
    AST_OL_REPORT: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        olst_reg == ($past(ol_active) && $past(ol_sync)))
        else $error("open-load status does not follow comparator");
    AST_RESUME: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        $fell(ocf_reg) ##0 en_reg && en_next && src_on && !oc_event
        |=> drv_on)
        else $error("driver did not resume after clear");
    AST_RESET_QUIET: assert property (
        @(posedge clk_sys)
        !$past(rst_n) && !rst_n
        |-> !drv_bias && !drv_on && !irq_req && !ol_detect_on)
        else $error("outputs active during reset");
endmodule

//--- bench/hsd_stage_model.sv
// Behavioural output stage and load seen from the control block
`timescale 1ns/100ps
module hsd_stage_model #(
    parameter int RESP_NS = 0
) (
    input wire logic drv_bias,
    input wire logic drv_on,
    input wire logic ol_detect_on,
    input wire logic load_open,
    input wire logic short_fault,
    output logic oc_comp_in,
    output logic ol_comp_in
);
    // Current only flows into a short while the stage is biased and on
    assign #RESP_NS oc_comp_in = drv_bias & drv_on & short_fault;
    // Pin floats high only with the test current on and no load attached
    assign #RESP_NS ol_comp_in = ol_detect_on & load_open;
endmodule

//--- bench/tb_hsd_top.sv
// Self-checking bench for the high-side driver control block
`timescale 1ns/100ps
module tb_hsd_top;
    import hsd_pkg::*;
    logic clk_sys, rst_n, bus_wr, bus_rd, route_sel_timer, timer_pwm_in;
    logic run_mode, oc_comp_in, ol_comp_in, drv_bias, drv_on;
    logic ol_detect_on, irq_req, load_open, short_fault;
    hsd_addr_t bus_addr;
    hsd_byte_t bus_wdata, bus_rdata;
    int n_errors = 0;
    int n_checks = 0;

    hsd_top #(.MASK_CYCLES(4)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .route_sel_timer(route_sel_timer), .timer_pwm_in(timer_pwm_in),
        .run_mode(run_mode), .oc_comp_in(oc_comp_in),
        .ol_comp_in(ol_comp_in), .drv_bias(drv_bias), .drv_on(drv_on),
        .ol_detect_on(ol_detect_on), .irq_req(irq_req));

    // Slow comparators so the synchronisers see late edges
    hsd_stage_model #(.RESP_NS(30)) stage_u (.drv_bias(drv_bias),
        .drv_on(drv_on), .ol_detect_on(ol_detect_on),
        .load_open(load_open), .short_fault(short_fault),
        .oc_comp_in(oc_comp_in), .ol_comp_in(ol_comp_in));

    // ****************************************
    // Bus and checking tasks
    // ****************************************
    task chk(input string name, input hsd_byte_t seen, input hsd_byte_t exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task wr(input hsd_addr_t a, input hsd_byte_t d);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clk_sys);
        bus_wr <= 1'b0;
    endtask

    task rd(input hsd_addr_t a, input hsd_byte_t exp);
        @(posedge clk_sys);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clk_sys);
        bus_rd <= 1'b0;
        @(negedge clk_sys);
        chk("bus_rdata", bus_rdata, exp);
    endtask

    task print_verdict;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // Whole run is under two hundred cycles; 4000 cycles is a generous bound
    initial begin
        #(40 * 4000);
        n_errors++;
        print_verdict;
    end

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        rst_n = 1'b0;
        bus_addr = '0;
        bus_wdata = '0;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        route_sel_timer = 1'b0;
        timer_pwm_in = 1'b0;
        run_mode = 1'b1;
        load_open = 1'b0;
        short_fault = 1'b0;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        cyc(1);
        chk("outputs", 8'({drv_bias, drv_on, ol_detect_on, irq_req}),
            8'h00);
        for (int i = 0; i < 8; i++) rd(hsd_addr_t'(i), 8'h00);
        wr(3'h1, 8'h11);
        rd(3'h1, 8'h11);
        chk("drv_bias", 8'(drv_bias), 8'h01);
        wr(3'h1, 8'h00);
        rd(3'h1, 8'h10);
        wr(3'h1, 8'h11);
        cyc(4);
        @(posedge clk_sys);
        short_fault <= 1'b1;
        wr(3'h0, 8'h01);
        for (int i = 0; i < 10 && drv_on !== 1'b1; i++) cyc(1);
        cyc(3);
        chk("drv_on_masked", 8'(drv_on), 8'h01);
        for (int i = 0; i < 12 && drv_on !== 1'b0; i++) cyc(1);
        chk("drv_on_tripped", 8'(drv_on), 8'h00);
        rd(3'h7, 8'h01);
        chk("irq_req_off", 8'(irq_req), 8'h00);
        wr(3'h7, 8'h00);
        rd(3'h7, 8'h01);
        @(posedge clk_sys);
        short_fault <= 1'b0;
        wr(3'h7, 8'h01);
        rd(3'h7, 8'h00);
        cyc(2);
        chk("drv_on_back", 8'(drv_on), 8'h01);
        wr(3'h6, 8'h80);
        rd(3'h6, 8'h80);
        @(posedge clk_sys);
        short_fault <= 1'b1;
        for (int i = 0; i < 12 && irq_req !== 1'b1; i++) cyc(1);
        chk("irq_req_on", 8'(irq_req), 8'h01);
        chk("drv_on_irq", 8'(drv_on), 8'h00);
        @(posedge clk_sys);
        run_mode <= 1'b0;
        cyc(2);
        chk("irq_req_stop", 8'(irq_req), 8'h00);
        rd(3'h7, 8'h01);
        @(posedge clk_sys);
        run_mode <= 1'b1;
        cyc(2);
        chk("irq_req_run", 8'(irq_req), 8'h01);
        @(posedge clk_sys);
        short_fault <= 1'b0;
        wr(3'h7, 8'h01);
        cyc(2);
        chk("irq_req_clr", 8'(irq_req), 8'h00);
        @(posedge clk_sys);
        route_sel_timer <= 1'b1;
        cyc(5);
        chk("drv_on_timer0", 8'(drv_on), 8'h00);
        @(posedge clk_sys);
        timer_pwm_in <= 1'b1;
        cyc(5);
        chk("drv_on_timer1", 8'(drv_on), 8'h01);
        @(posedge clk_sys);
        timer_pwm_in <= 1'b0;
        load_open <= 1'b1;
        wr(3'h1, 8'h15);
        cyc(6);
        chk("ol_detect_on", 8'(ol_detect_on), 8'h01);
        rd(3'h5, 8'h01);
        wr(3'h5, 8'hFF);
        rd(3'h5, 8'h01);
        @(posedge clk_sys);
        load_open <= 1'b0;
        cyc(5);
        rd(3'h5, 8'h00);
        @(posedge clk_sys);
        timer_pwm_in <= 1'b1;
        cyc(5);
        chk("ol_detect_src_on", 8'(ol_detect_on), 8'h00);
        wr(3'h1, 8'h00);
        cyc(3);
        chk("disabled", 8'({drv_bias, drv_on}), 8'h00);
        print_verdict;
    end
endmodule
